// ===== hw/cpg_consts.vh
// Constants for the crystal and loop base clock generator
`ifndef CPG_CONSTS_VH
`define CPG_CONSTS_VH
// ==========================================
// Register byte offsets
`define CPG_REG_CTRL 8'h00
`define CPG_REG_STAT 8'h04
`define CPG_REG_IRQ_STATUS 8'h08
`define CPG_REG_IRQ_MASK 8'h0c
`define CPG_REG_MULT 8'h10
// ==========================================
// Control register fields
`define CPG_CTRL_SEL 0
`define CPG_CTRL_AUTO 1
`define CPG_CTRL_ACQ 2
`define CPG_CTRL_LOCKIE 3
// ==========================================
// Status register fields
`define CPG_STAT_LOCK 0
`define CPG_STAT_TRACK 1
`define CPG_STAT_SRC 2
// ==========================================
// Interrupt status fields
`define CPG_IRQ_LOCK_IN 0
`define CPG_IRQ_LOCK_OUT 1
// ==========================================
// Reset values
`define CPG_CTRL_RESET 4'h2
`define CPG_MULT_RESET 8'h08
`define CPG_MASK_RESET 2'h0
// ==========================================
// AXI responses
`define CPG_RESP_OKAY 2'h0
`define CPG_RESP_SLVERR 2'h2
`endif

// ===== hw/cpg_clock_gen.v
// Crystal clock, loop reference, base clock selector, lock detector and register slave
//
// Summary of operation
// - Base clock comes from either halved crystal clock or halved VCO clock only.
// - Software control bit chooses the base clock source, never hardware on its own.
// - Oscillator runs only while the integration unit asserts its enable input.
// - Crystal-rate clock passes out at crystal rate and buffered as loop reference.
// - Loop frequency is a software-set integer multiple of the reference.
// - Interrupt can be requested on lock entry and on lock exit.
// - Automatic lock detector and automatic wide/narrow bandwidth switching exist.
// - In automatic mode, a lock toggle with interrupt enable and its mask bit set raises a request.
// - In manual mode lock indication is inactive and all interrupts are suppressed.
// - Filter tracks when not acquiring, or whenever the acquire/track bit is set.
// - Select bit one takes halved VCO clock, zero takes halved crystal clock.
//
// Chosen here: the address map and register access over AXI4-Lite.
`timescale 1ns/10ps
`include "cpg_consts.vh"
module cpg_clock_gen #(
	parameter MULT_W = 8,
	parameter LOCK_WIN = 8'h02,
	parameter LOCK_SPAN = 8'h40
) (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// Crystal amplifier and integration unit
	input wire crystal_amp_input,
	output wire crystal_amp_output,
	output wire crystal_amp_output_en,
	input wire oscillator_enable_in,
	// Loop oscillator sample
	input wire vco_output_clock,
	// Clock and loop control outputs
	output wire crystal_rate_clock,
	output wire loop_reference_clock,
	output reg base_clock_out,
	output reg [MULT_W-1:0] loop_multiplier,
	output wire filter_track_mode,
	// Interrupt
	output wire clockgen_interrupt_request,
	// AXI4-Lite write address
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	// AXI4-Lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	// AXI4-Lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// AXI4-Lite read address
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	// AXI4-Lite read data
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready
);
	// ==========================================
	// Crystal oscillator
	// Amplifier always inverts; output driven only while enabled, released otherwise
	assign crystal_amp_output = ~crystal_amp_input;
	assign crystal_amp_output_en = oscillator_enable_in;
	// ==========================================
	// Pin synchronisers
	// Three flip-flops per pin; a level counts once the second and third agree
	wire [1:0] pin_raw = {vco_output_clock, crystal_amp_input & oscillator_enable_in};
	wire [1:0] pin_level;
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
			reg [2:0] stage;
			reg level;
			always @(posedge aclk) begin
				if (!aresetn) begin
					stage <= 3'h0;
					level <= 1'b0;
				end else begin
					stage <= {stage[1:0], pin_raw[gi]};
					if (stage[2] == stage[1])
						level <= stage[1];
				end
			end
			assign pin_level[gi] = level;
		end
	endgenerate
	wire xclk = pin_level[0];
	wire vclk = pin_level[1];
	// Sampled copy; duty cycle follows the crystal, not corrected here
	assign crystal_rate_clock = xclk;
	assign loop_reference_clock = xclk;
	// ==========================================
	// Registers
	reg [3:0] ctrl;
	reg [1:0] irq_status;
	reg [1:0] irq_mask;
	reg lock;
	reg acq_auto;
	wire sel = ctrl[`CPG_CTRL_SEL];
	wire auto_mode = ctrl[`CPG_CTRL_AUTO];
	wire lock_ie = ctrl[`CPG_CTRL_LOCKIE];
	// Acquire/track bit is written in manual mode, read-only mirror in automatic mode
	wire acq_bit = auto_mode ? acq_auto : ctrl[`CPG_CTRL_ACQ];
	// ==========================================
	// Edge counters and lock detector
	reg xclk_d;
	reg vclk_d;
	reg [7:0] xcnt;
	reg [15:0] vcnt;
	wire x_rise = xclk & ~xclk_d;
	wire v_rise = vclk & ~vclk_d;
	// One window is LOCK_SPAN reference edges; expected VCO edges scale with multiplier
	wire [15:0] expect_cnt = LOCK_SPAN * {8'h00, loop_multiplier};
	wire [15:0] diff = (vcnt > expect_cnt) ? vcnt - expect_cnt : expect_cnt - vcnt;
	wire win_end = x_rise && (xcnt == LOCK_SPAN - 8'h01);
	wire near_lock = diff <= {8'h00, LOCK_WIN};
	wire near_track = diff <= {7'h00, LOCK_WIN, 1'b0};
	wire next_lock = auto_mode & near_lock;
	reg lock_prev;
	always @(posedge aclk) begin
		if (!aresetn) begin
			xclk_d <= 1'b0;
			vclk_d <= 1'b0;
			xcnt <= 8'h00;
			vcnt <= 16'h0000;
			lock <= 1'b0;
			acq_auto <= 1'b0;
		end else begin
			xclk_d <= xclk;
			vclk_d <= vclk;
			if (win_end) begin
				xcnt <= 8'h00;
				vcnt <= 16'h0000;
				lock <= next_lock;
				acq_auto <= near_track;
			end else begin
				if (x_rise)
					xcnt <= xcnt + 8'h01;
				if (v_rise)
					vcnt <= vcnt + 16'h0001;
			end
			if (!auto_mode) begin
				lock <= 1'b0;
				acq_auto <= 1'b0;
			end
		end
	end
	// ==========================================
	// Base clock selector
	// Each source halved. A switch parks the output low once the old half is low,
	// then hands over at a falling edge of the new half, so no pulse is cut short.
	// Limitation: a dead new source keeps the output parked low until it runs.
	reg xdiv;
	reg vdiv;
	reg src;
	reg park;
	wire x_fall = x_rise & xdiv;
	wire v_fall = v_rise & vdiv;
	wire old_low = src ? !vdiv : !xdiv;
	wire new_fall = sel ? v_fall : x_fall;
	always @(posedge aclk) begin
		if (!aresetn) begin
			xdiv <= 1'b0;
			vdiv <= 1'b0;
			src <= 1'b0;
			park <= 1'b0;
			base_clock_out <= 1'b0;
		end else begin
			if (x_rise)
				xdiv <= ~xdiv;
			if (v_rise)
				vdiv <= ~vdiv;
			if (!park && sel != src && old_low)
				park <= 1'b1;
			if (park && new_fall) begin
				src <= sel;
				park <= 1'b0;
			end
			base_clock_out <= park ? 1'b0 : (src ? vdiv : xdiv);
		end
	end
	// ==========================================
	// Interrupt events
	wire ev_in = lock & ~lock_prev;
	wire ev_out = ~lock & lock_prev;
	wire [1:0] events = {ev_out, ev_in} & {2{auto_mode & lock_ie}};
	// ==========================================
	// Output registers
	// Registered so no decode glitch reaches the interrupt or filter pins
	reg irq_q;
	reg track_q;
	always @(posedge aclk) begin
		if (!aresetn) begin
			irq_q <= 1'b0;
			track_q <= 1'b0;
		end else begin
			irq_q <= auto_mode & |(irq_status & irq_mask);
			track_q <= acq_bit;
		end
	end
	assign clockgen_interrupt_request = irq_q;
	assign filter_track_mode = track_q;
	// ==========================================
	// AXI4-Lite write channel
	reg aw_held;
	reg w_held;
	reg [7:0] aw_addr;
	reg [31:0] w_data;
	reg [3:0] w_strb;
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	wire aw_now = aw_held | s_axi_awvalid;
	wire w_now = w_held | s_axi_wvalid;
	wire [7:0] wa = aw_held ? aw_addr : s_axi_awaddr;
	wire [31:0] wd = w_held ? w_data : s_axi_wdata;
	wire [3:0] ws = w_held ? w_strb : s_axi_wstrb;
	wire wr_go = aw_now && w_now && !s_axi_bvalid;
	wire wr_hit = (wa == `CPG_REG_CTRL) || (wa == `CPG_REG_IRQ_STATUS) ||
		(wa == `CPG_REG_IRQ_MASK) || (wa == `CPG_REG_MULT) || (wa == `CPG_REG_STAT);
	wire [1:0] w1c = (wr_go && wa == `CPG_REG_IRQ_STATUS && ws[0]) ? wd[1:0] : 2'h0;
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `CPG_RESP_OKAY;
			ctrl <= `CPG_CTRL_RESET;
			irq_mask <= `CPG_MASK_RESET;
			irq_status <= 2'h0;
			loop_multiplier <= `CPG_MULT_RESET;
			lock_prev <= 1'b0;
		end else begin
			lock_prev <= lock;
			// Set wins over a simultaneous clear
			irq_status <= (irq_status & ~w1c) | events;
			if (s_axi_awvalid && s_axi_awready && !wr_go) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready && !wr_go) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? `CPG_RESP_OKAY : `CPG_RESP_SLVERR;
				if (ws[0]) begin
					if (wa == `CPG_REG_CTRL)
						ctrl <= wd[3:0];
					if (wa == `CPG_REG_IRQ_MASK)
						irq_mask <= wd[1:0];
					// Zero would stop the loop; kept at one or more
					if (wa == `CPG_REG_MULT && wd[MULT_W-1:0] != {MULT_W{1'b0}})
						loop_multiplier <= wd[MULT_W-1:0];
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end
	// ==========================================
	// AXI4-Lite read channel
	assign s_axi_arready = !s_axi_rvalid;
	reg [31:0] rd;
	reg rd_hit;
	always @* begin
		rd = 32'h00000000;
		rd_hit = 1'b1;
		case (s_axi_araddr)
			`CPG_REG_CTRL: rd = {28'h0000000, lock_ie, acq_bit, auto_mode, sel};
			`CPG_REG_STAT: rd = {29'h00000000, src, acq_bit, lock};
			`CPG_REG_IRQ_STATUS: rd = {30'h00000000, irq_status};
			`CPG_REG_IRQ_MASK: rd = {30'h00000000, irq_mask};
			`CPG_REG_MULT: rd = {{(32-MULT_W){1'b0}}, loop_multiplier};
			default: rd_hit = 1'b0;
		endcase
	end
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `CPG_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd;
			s_axi_rresp <= rd_hit ? `CPG_RESP_OKAY : `CPG_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule

// ===== verif/cpg_clock_gen_sva.sv
// Port checker for the base clock generator
`timescale 1ns/10ps
// ==========
// Checker
module cpg_clock_gen_sva #(
	parameter MULT_W = 8
) (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// Pins and clocks
	input wire crystal_amp_input,
	input wire crystal_amp_output,
	input wire crystal_amp_output_en,
	input wire oscillator_enable_in,
	input wire crystal_rate_clock,
	input wire loop_reference_clock,
	input wire base_clock_out,
	input wire [MULT_W-1:0] loop_multiplier,
	input wire clockgen_interrupt_request,
	// Bus handshakes
	input wire s_axi_awvalid,
	input wire s_axi_wvalid,
	input wire s_axi_bvalid,
	input wire s_axi_arvalid,
	input wire s_axi_rvalid
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	amp_en_a: assert property (crystal_amp_output_en == oscillator_enable_in)
		else $error("amplifier enable differs from oscillator enable");
	amp_inv_a: assert property (oscillator_enable_in |-> crystal_amp_output != crystal_amp_input)
		else $error("amplifier output not inverted");
	xclk_off_a: assert property (!oscillator_enable_in [*5] |-> !crystal_rate_clock)
		else $error("crystal clock runs while disabled");
	ref_buf_a: assert property (loop_reference_clock == crystal_rate_clock)
		else $error("reference clock differs from crystal clock");
	// A halved clock keeps each level for two samples at least
	bclk_high_a: assert property ($rose(base_clock_out) |=> base_clock_out)
		else $error("short high pulse on base clock");
	bclk_low_a: assert property ($fell(base_clock_out) |=> !base_clock_out)
		else $error("short low pulse on base clock");
	mult_nz_a: assert property (loop_multiplier != 0)
		else $error("multiplier is zero");
	wresp_lat_a: assert property ($rose(s_axi_bvalid) |-> $past(s_axi_awvalid || s_axi_wvalid))
		else $error("write response without request");
	rresp_lat_a: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid))
		else $error("read response without request");
	cover property ($rose(clockgen_interrupt_request));
	cover property ($fell(clockgen_interrupt_request));
	cover property ($rose(base_clock_out));
endmodule
bind cpg_clock_gen cpg_clock_gen_sva #(.MULT_W(MULT_W)) chk_u (.aclk, .aresetn,
	.crystal_amp_input, .crystal_amp_output, .crystal_amp_output_en, .oscillator_enable_in,
	.crystal_rate_clock, .loop_reference_clock, .base_clock_out, .loop_multiplier,
	.clockgen_interrupt_request, .s_axi_awvalid, .s_axi_wvalid, .s_axi_bvalid,
	.s_axi_arvalid, .s_axi_rvalid);

// ===== verif/cpg_sim_model.sv
// Integration unit model with crystal and loop oscillator sources
`timescale 1ns/10ps
// ==========
// Model
module cpg_sim_model #(
	parameter XHALF = 2000
) (
	// Control
	input wire aclk,
	input wire en_req,
	input wire [15:0] vco_half,
	// Clocks in
	input wire base_clock_out,
	input wire crystal_rate_clock,
	// Sources out
	output reg oscillator_enable_in = 1'b0,
	output reg crystal_amp_input = 1'b0,
	output reg vco_output_clock = 1'b0,
	output reg sys_clk = 1'b0
);
	always @(posedge aclk) oscillator_enable_in <= en_req;
	// A dead crystal does not swing, so the pin rests low
	always #XHALF crystal_amp_input = oscillator_enable_in ? !crystal_amp_input : 1'b0;
	always #(vco_half) vco_output_clock = !vco_output_clock;
	// Rising edges only, so duty cycle never matters
	always @(posedge base_clock_out) sys_clk <= !sys_clk;
endmodule

// ===== verif/cpg_clock_gen_tb.sv
// Self-checking bench for the base clock generator
`timescale 1ns/10ps
module cpg_clock_gen_tb;
	reg aclk = 0, aresetn = 0, en_req = 0, awvalid = 0, wvalid = 0, bready = 0;
	reg arvalid = 0, rready = 0;
	reg [7:0] awaddr = 0, araddr = 0, mult_exp;
	reg [31:0] wdata = 0, rd_v = 0, seed = 32'h99c5e1be;
	reg [15:0] vco_half = 16'd500;
	reg [1:0] resp;
	wire awready, wready, bvalid, arready, rvalid, irq, osc_en, xtal, vco, xclk, base, track;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	integer fails = 0, check_count = 0, n, i, k, bper;
	reg bprev = 0;
	localparam XHALF = 2000;
	initial forever #50 aclk = !aclk;
	cpg_sim_model #(.XHALF(XHALF)) sim_u (.aclk(aclk), .en_req(en_req), .vco_half(vco_half),
		.base_clock_out(base), .crystal_rate_clock(xclk), .oscillator_enable_in(osc_en),
		.crystal_amp_input(xtal), .vco_output_clock(vco), .sys_clk());
	cpg_clock_gen #(.LOCK_SPAN(8'h10)) dut_u (.aclk(aclk), .aresetn(aresetn),
		.crystal_amp_input(xtal), .crystal_amp_output(), .crystal_amp_output_en(),
		.oscillator_enable_in(osc_en), .vco_output_clock(vco), .crystal_rate_clock(xclk),
		.loop_reference_clock(), .base_clock_out(base), .loop_multiplier(),
		.filter_track_mode(track), .clockgen_interrupt_request(irq), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	task summarize;
		begin
			$display("checks %0d fails %0d", check_count, fails);
			if (fails == 0 && check_count > 0) begin
				$display("RESULT: PASS");
			end else begin
				$display("RESULT: FAIL");
			end
			$finish;
		end
	endtask
	task chk(input string nm, input [31:0] seen, input [31:0] exp);
		begin
			check_count = check_count + 1;
			if (seen !== exp) begin
				fails = fails + 1;
				$display("unexpected %s expected %h seen %h", nm, exp, seen);
			end
		end
	endtask
	task tmo(input ok);
		if (!ok) begin
			fails = fails + 1;
			summarize;
		end
	endtask
	// Handshakes are sampled at the falling edge, where inputs are settled
	task wr(input [7:0] a, input [31:0] d);
		reg ta, tw, tb;
		begin
			@(posedge aclk);
			awaddr <= a;
			wdata <= d;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
			tb = 0;
			for (n = 0; n < 200 && !tb; n = n + 1) begin
				@(negedge aclk);
				ta = awvalid && awready;
				tw = wvalid && wready;
				tb = bvalid;
				resp = bresp;
				@(posedge aclk);
				if (ta) awvalid <= 1'b0;
				if (tw) wvalid <= 1'b0;
			end
			bready <= 1'b0;
			tmo(tb);
		end
	endtask
	task rd(input [7:0] a);
		reg ta, tr;
		begin
			@(posedge aclk);
			araddr <= a;
			arvalid <= 1'b1;
			rready <= 1'b1;
			tr = 0;
			for (n = 0; n < 200 && !tr; n = n + 1) begin
				@(negedge aclk);
				ta = arvalid && arready;
				tr = rvalid;
				rd_v = rdata;
				resp = rresp;
				@(posedge aclk);
				if (ta) arvalid <= 1'b0;
			end
			rready <= 1'b0;
			tmo(tr);
		end
	endtask
	task poll(input [7:0] a, input [31:0] m, input [31:0] e);
		begin
			rd(a);
			for (i = 0; i < 60 && (rd_v & m) !== e; i = i + 1) rd(a);
		end
	endtask
	task wait_irq(input e);
		begin
			for (i = 0; i < 4000 && irq !== e; i = i + 1) @(negedge aclk);
			tmo(irq === e);
		end
	endtask
	// Cycles between two rising edges of the base clock, seen at falling edges
	task bclk_per;
		integer c, e;
		begin
			e = 0;
			bper = 0;
			bprev = base;
			for (c = 0; c < 400 && e < 2; c = c + 1) begin
				@(negedge aclk);
				if (base && !bprev)
					e = e + 1;
				if (e == 1)
					bper = bper + 1;
				bprev = base;
			end
			tmo(e == 2);
		end
	endtask
	// Halved source: two source periods of four half periods, in 100 ns cycles
	function integer bclk_cycles(input integer half_ns);
		bclk_cycles = 4 * half_ns / 100;
	endfunction
	function [31:0] lfsr(input [31:0] x);
		lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	function [7:0] mult_after(input [7:0] prev, input [7:0] v);
		mult_after = (v == 8'h00) ? prev : v;
	endfunction
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		en_req <= 1'b1;
		rd(8'h00); chk("ctrl", rd_v, 32'h2);
		rd(8'h0c); chk("mask", rd_v, 32'h0);
		rd(8'h14); chk("rresp", resp, 32'h2);
		wr(8'h14, 32'h1); chk("bresp", resp, 32'h2);
		mult_exp = 8'h08;
		// Zero is drawn about half the time to hit the ignored write
		for (k = 0; k < 6; k = k + 1) begin
			seed = lfsr(seed);
			wr(8'h10, {24'h0, seed[7:0] & {8{seed[8]}}});
			mult_exp = mult_after(mult_exp, seed[7:0] & {8{seed[8]}});
			rd(8'h10); chk("mult", rd_v, {24'h0, mult_exp});
		end
		wr(8'h10, 32'h4);
		wr(8'h0c, 32'h3);
		wr(8'h00, 32'ha);
		wait_irq(1'b1); chk("irq", irq, 32'h1);
		rd(8'h04); chk("lock", rd_v[0], 32'h1);
		rd(8'h08); chk("entry", rd_v, 32'h1);
		wr(8'h08, 32'h1); @(negedge aclk); chk("irq", irq, 32'h0);
		wr(8'h00, 32'hb); poll(8'h04, 32'h4, 32'h4); chk("src", rd_v[2], 32'h1);
		bclk_per; chk("base period", bper, bclk_cycles(vco_half));
		wr(8'h00, 32'ha); poll(8'h04, 32'h4, 32'h0); chk("src", rd_v[2], 32'h0);
		bclk_per; chk("base period", bper, bclk_cycles(XHALF));
		vco_half <= 16'd250;
		wait_irq(1'b1); rd(8'h08); chk("exit", rd_v, 32'h2);
		wr(8'h00, 32'hc); @(negedge aclk); chk("irq", irq, 32'h0);
		chk("track", track, 32'h1);
		rd(8'h04); chk("lock", rd_v[0], 32'h0);
		wr(8'h00, 32'h0); @(negedge aclk); chk("track", track, 32'h0);
		en_req <= 1'b0;
		repeat (10) @(posedge aclk);
		chk("xclk", xclk, 32'h0);
		summarize;
	end
endmodule
